// *** core/rtcc_pkg.sv ***
// Purpose: shared constants and types of the clock control, status and interrupt block
// Assumes: 100 MHz core clock; register offsets are six-bit byte addresses
// Notes:   times are kept in microseconds and turned into cycles here
package rtcc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned T_BUC_US     = 244;
  localparam int unsigned T_UC_FAST_US = 248;
  localparam int unsigned T_UC_SLOW_US = 1984;
  localparam int unsigned BUC_CYC      = T_BUC_US * CLK_MHZ;
  localparam int unsigned UC_FAST_CYC  = T_UC_FAST_US * CLK_MHZ;
  localparam int unsigned UC_SLOW_CYC  = T_UC_SLOW_US * CLK_MHZ;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] ADDR_RATE_CTRL = 6'h0A;
  localparam logic [5:0] ADDR_UPD_CTRL  = 6'h0B;
  localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h0C;
  localparam logic [5:0] ADDR_PWR_VALID = 6'h0D;
  localparam logic [7:0] REG_ZERO       = 8'h00;

  localparam int unsigned A_UIP_BIT  = 7;
  localparam int unsigned A_BASE_LSB = 4;
  localparam int unsigned A_RATE_LSB = 0;
  localparam int unsigned B_SET_BIT  = 7;
  localparam int unsigned B_PIE_BIT  = 6;
  localparam int unsigned B_AIE_BIT  = 5;
  localparam int unsigned B_UIE_BIT  = 4;
  localparam int unsigned B_SQUARE_WAVE_ENABLE_BIT = 3;
  localparam int unsigned B_DM_BIT   = 2;
  localparam int unsigned B_H24_BIT  = 1;
  localparam int unsigned B_DSE_BIT  = 0;
  localparam int unsigned C_IRQF_BIT = 7;
  localparam int unsigned C_PF_BIT   = 6;
  localparam int unsigned C_AF_BIT   = 5;
  localparam int unsigned C_UF_BIT   = 4;
  localparam int unsigned D_VRT_BIT  = 7;

  // ****************************************
  // time base and divider
  // ****************************************
  localparam logic [2:0] BASE_FAST4 = 3'h0;
  localparam logic [2:0] BASE_FAST1 = 3'h1;
  localparam logic [2:0] BASE_SLOW  = 3'h2;
  localparam logic [3:0] RATE_OFF   = 4'h0;
  localparam int unsigned SEC_IDX_FAST4 = 22;
  localparam int unsigned SEC_IDX_FAST1 = 20;
  localparam int unsigned SEC_IDX_SLOW  = 15;
  localparam int unsigned TAP_OFS_FAST4 = 7;
  localparam int unsigned TAP_OFS_FAST1 = 5;
  localparam int unsigned TAP_OFS_SLOW  = 0;

  typedef enum logic [1:0] {UPD_IDLE, UPD_PRE, UPD_RUN} rtcc_upd_e;

endpackage

// *** core/rtcc_divider.sv ***
// Purpose: time-base divider chain giving the second tick, the periodic tick and the tap level
// Assumes: osc_tick_in pulses once per time-base cycle, synchronous to ref_clk_in
// Notes:   an unknown time-base code holds the chain in reset
`timescale 1ns/1ns
module rtcc_divider
  import rtcc_pkg::*;
#(
  parameter int unsigned DIV_W = 22
) (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       osc_tick_in,
  input  wire logic [2:0] base_sel_in,
  input  wire logic [3:0] rate_select_in,
  output logic            sec_tick_out,
  output logic            per_tick_out,
  output logic            tap_level_out
);

  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic             sec_ff, nxt_sec, per_ff, nxt_per, tap_ff, nxt_tap;
  logic [DIV_W:0]   sec_mask, tap_mask;
  int unsigned      sec_idx, tap_idx;
  logic             base_ok;

  always_comb begin
    base_ok = 1'b1;
    sec_idx = SEC_IDX_SLOW;
    tap_idx = TAP_OFS_SLOW;
    unique case (base_sel_in)
      BASE_FAST4: begin sec_idx = SEC_IDX_FAST4; tap_idx = TAP_OFS_FAST4; end
      BASE_FAST1: begin sec_idx = SEC_IDX_FAST1; tap_idx = TAP_OFS_FAST1; end
      BASE_SLOW:  begin sec_idx = SEC_IDX_SLOW;  tap_idx = TAP_OFS_SLOW;  end
      default:    base_ok = 1'b0;
    endcase
    // rate code n picks divider bit n-1 above the base offset
    tap_idx  = tap_idx + 32'(rate_select_in) - 1;
    if (tap_idx >= DIV_W) begin
      tap_idx = DIV_W - 1;
    end
    sec_mask = ((DIV_W+1)'(1) << sec_idx) - (DIV_W+1)'(1);
    tap_mask = ((DIV_W+1)'(1) << tap_idx) - (DIV_W+1)'(1);
    nxt_cnt  = base_ok ? (osc_tick_in ? cnt_ff + DIV_W'(1) : cnt_ff) : '0;
    nxt_sec  = base_ok & osc_tick_in & (({1'b0, cnt_ff} & sec_mask) == sec_mask);
    // periodic event on the falling edge of the selected tap
    nxt_per  = base_ok & osc_tick_in & (rate_select_in != RATE_OFF) & cnt_ff[tap_idx]
             & (({1'b0, cnt_ff} & tap_mask) == tap_mask);
    nxt_tap  = base_ok & (rate_select_in != RATE_OFF) & cnt_ff[tap_idx];
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= '0;
      sec_ff <= 1'b0;
      per_ff <= 1'b0;
      tap_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sec_ff <= nxt_sec;
      per_ff <= nxt_per;
      tap_ff <= nxt_tap;
    end
  end

  assign sec_tick_out  = sec_ff;
  assign per_tick_out  = per_ff;
  assign tap_level_out = tap_ff;

endmodule

// *** core/rtcc_top.sv ***
// Purpose: update timing, control register, interrupt flags and validity status of a time-of-day clock
// Assumes: register port is synchronous; chip_clear_n_in and power_sense_input_in are synchronous levels
// Notes:   the time counters sit outside and follow advance_time_out and the format outputs
//
// Contract
// RL1: update run lasts 248 or 1984 us, busy flag set throughout
// RL2: flag low means 244 us before update
// RL3: hold bit aborts and stops updates
// RL4: chip clear drops the three enables, wave enable and the three flags only
// RL5: periodic enable gates periodic flag to request
// RL6: update-done enable gates its flag to request
// RL7: wave pin follows tap, else low
// RL8: format bit selects binary or decimal
// RL9: hour bit selects 24 or 12 hours
// RL10: summer-time enable drives special hour jumps
// RL11: summary flag ORs enabled flags, drives pin
// RL12: reading flags clears them; writes ignored
// RL13: periodic flag sets on tap edge always
// RL14: alarm match sets alarm flag
// RL15: update end sets update-done flag
// RL16: low four flag bits read zero
// RL17: valid bit zero while power sense low
// RL18: reading validity register sets valid bit
// RL19: low seven validity bits read zero
// RL20: request pin released when nothing pending
// RL21: busy flag read-only, shows pending update
`timescale 1ns/1ns
module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int unsigned DIV_W       = 22,
  parameter int unsigned BUC_CYCLES  = BUC_CYC,
  parameter int unsigned UC_FAST_CYCLES = UC_FAST_CYC,
  parameter int unsigned UC_SLOW_CYCLES = UC_SLOW_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       chip_clear_n_in,
  input  wire logic       osc_tick_in,
  input  wire logic       power_sense_input_in,
  input  wire logic       alarm_match_in,
  input  wire logic       bus_sel_in,
  input  wire logic       bus_rd_in,
  input  wire logic       bus_wr_in,
  input  wire logic [5:0] bus_addr_in,
  input  wire logic [7:0] bus_wdata_in,
  output logic      [7:0] bus_rdata_out,
  output logic            irq_n_out,
  output logic            irq_oe_out,
  output logic            wave_out_pin_out,
  output logic            advance_time_out,
  output logic            data_format_select_out,
  output logic            hour_format_24_out,
  output logic            summer_time_enable_out
);

  localparam int unsigned CW = $clog2(UC_SLOW_CYCLES + 1);

  // ****************************************
  // divider
  // ****************************************
  logic sec_tick, per_tick, tap_level;
  logic [3:0] rate_ff, nxt_rate;
  logic [2:0] base_ff, nxt_base;

  rtcc_divider #(.DIV_W(DIV_W)) u_div (
    .ref_clk_in     (ref_clk_in),
    .nrst_in        (nrst_in),
    .osc_tick_in    (osc_tick_in),
    .base_sel_in    (base_ff),
    .rate_select_in (rate_ff),
    .sec_tick_out   (sec_tick),
    .per_tick_out   (per_tick),
    .tap_level_out  (tap_level)
  );

  // ****************************************
  // register port decode
  // ****************************************
  logic       set_ff, pie_ff, aie_ff, uie_ff, square_wave_enable_ff, dm_ff, h24_ff, dse_ff;
  logic       nxt_set, nxt_pie, nxt_aie, nxt_uie, nxt_square_wave_enable, nxt_dm, nxt_h24, nxt_dse;
  logic       pf_ff, af_ff, uf_ff, vrt_ff, nxt_pf, nxt_af, nxt_uf, nxt_vrt;
  logic [7:0] rdata_ff, nxt_rdata, rd_val;
  logic       irq_oe_ff, nxt_irq_oe, wave_ff, nxt_wave, irqf;
  logic       wr_a, wr_b, rd_c, rd_d, rd_hit;
  rtcc_upd_e  state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic       uip_ff, nxt_uip, adv_ff, nxt_adv;

  always_comb begin
    rd_hit = bus_sel_in & bus_rd_in;
    wr_a   = bus_sel_in & bus_wr_in & (bus_addr_in == ADDR_RATE_CTRL);
    wr_b   = bus_sel_in & bus_wr_in & (bus_addr_in == ADDR_UPD_CTRL);
    rd_c   = rd_hit & (bus_addr_in == ADDR_IRQ_FLAGS);
    rd_d   = rd_hit & (bus_addr_in == ADDR_PWR_VALID);
  end

  // ****************************************
  // control registers
  // ****************************************
  always_comb begin
    nxt_rate = wr_a ? bus_wdata_in[A_RATE_LSB +: 4] : rate_ff;
    nxt_base = wr_a ? bus_wdata_in[A_BASE_LSB +: 3] : base_ff;
    nxt_set  = wr_b ? bus_wdata_in[B_SET_BIT]  : set_ff;
    nxt_dm   = wr_b ? bus_wdata_in[B_DM_BIT]   : dm_ff;
    nxt_h24  = wr_b ? bus_wdata_in[B_H24_BIT]  : h24_ff;
    nxt_dse  = wr_b ? bus_wdata_in[B_DSE_BIT]  : dse_ff;
    nxt_pie  = wr_b ? bus_wdata_in[B_PIE_BIT]  : pie_ff;
    nxt_aie  = wr_b ? bus_wdata_in[B_AIE_BIT]  : aie_ff;
    nxt_uie  = wr_b ? bus_wdata_in[B_UIE_BIT]  : uie_ff;
    nxt_square_wave_enable = wr_b ? bus_wdata_in[B_SQUARE_WAVE_ENABLE_BIT] : square_wave_enable_ff;
    if (!chip_clear_n_in) begin // [RL4]
      nxt_pie  = 1'b0;
      nxt_aie  = 1'b0;
      nxt_uie  = 1'b0;
      nxt_square_wave_enable = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rate_ff <= '0;
      base_ff <= BASE_FAST4;
      set_ff  <= 1'b0;
      dm_ff   <= 1'b0;
      h24_ff  <= 1'b0;
      dse_ff  <= 1'b0;
      pie_ff  <= 1'b0;
      aie_ff  <= 1'b0;
      uie_ff  <= 1'b0;
      square_wave_enable_ff <= 1'b0;
    end else begin
      rate_ff <= nxt_rate;
      base_ff <= nxt_base;
      set_ff  <= nxt_set;
      dm_ff   <= nxt_dm;
      h24_ff  <= nxt_h24;
      dse_ff  <= nxt_dse;
      pie_ff  <= nxt_pie;
      aie_ff  <= nxt_aie;
      uie_ff  <= nxt_uie;
      square_wave_enable_ff <= nxt_square_wave_enable;
    end
  end

  // ****************************************
  // update cycle sequencer
  // ****************************************
  // the busy flag rises a full lead time before the update starts, so a
  // reader that sees it low always has that lead time to finish
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_adv   = 1'b0;
    unique case (state_ff)
      UPD_IDLE: begin
        if (sec_tick && !set_ff) begin // [RL3]
          nxt_state = UPD_PRE;
          nxt_cnt   = CW'(BUC_CYCLES - 1); // [RL2]
        end
      end
      UPD_PRE: begin
        if (cnt_ff == '0) begin
          nxt_state = UPD_RUN;
          nxt_cnt   = (base_ff == BASE_SLOW) ? CW'(UC_SLOW_CYCLES - 1) : CW'(UC_FAST_CYCLES - 1); // [RL1]
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
      UPD_RUN: begin
        if (cnt_ff == '0) begin
          nxt_state = UPD_IDLE;
          nxt_adv   = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
    endcase
    if (set_ff) begin // [RL3]
      nxt_state = UPD_IDLE;
      nxt_adv   = 1'b0;
    end
    nxt_uip = (nxt_state != UPD_IDLE); // [RL21]
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= UPD_IDLE;
      cnt_ff   <= '0;
      adv_ff   <= 1'b0;
      uip_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      adv_ff   <= nxt_adv;
      uip_ff   <= nxt_uip;
    end
  end

  // ****************************************
  // flags, validity, pins
  // ****************************************
  // a new event in the read cycle survives the clear; chip clear beats both
  always_comb begin
    irqf       = (pf_ff & pie_ff) | (af_ff & aie_ff) | (uf_ff & uie_ff); // [RL11]
    nxt_pf     = per_tick | (pf_ff & ~rd_c); // [RL13] [RL12]
    nxt_af     = alarm_match_in | (af_ff & ~rd_c); // [RL14]
    nxt_uf     = adv_ff | (uf_ff & ~rd_c); // [RL15]
    if (!chip_clear_n_in) begin
      nxt_pf = 1'b0;
      nxt_af = 1'b0;
      nxt_uf = 1'b0;
    end
    nxt_vrt    = power_sense_input_in & (vrt_ff | rd_d); // [RL17] [RL18]
    nxt_irq_oe = irqf & chip_clear_n_in; // [RL5] [RL6] [RL20]
    nxt_wave   = square_wave_enable_ff & tap_level; // [RL7]
    rd_val     = REG_ZERO;
    unique case (bus_addr_in)
      ADDR_RATE_CTRL: begin
        rd_val[A_UIP_BIT]         = uip_ff;
        rd_val[A_BASE_LSB +: 3]   = base_ff;
        rd_val[A_RATE_LSB +: 4]   = rate_ff;
      end
      ADDR_UPD_CTRL: begin
        rd_val[B_SET_BIT]  = set_ff;
        rd_val[B_PIE_BIT]  = pie_ff;
        rd_val[B_AIE_BIT]  = aie_ff;
        rd_val[B_UIE_BIT]  = uie_ff;
        rd_val[B_SQUARE_WAVE_ENABLE_BIT] = square_wave_enable_ff;
        rd_val[B_DM_BIT]   = dm_ff;
        rd_val[B_H24_BIT]  = h24_ff;
        rd_val[B_DSE_BIT]  = dse_ff;
      end
      ADDR_IRQ_FLAGS: begin // [RL16]
        rd_val[C_IRQF_BIT] = irqf;
        rd_val[C_PF_BIT]   = pf_ff;
        rd_val[C_AF_BIT]   = af_ff;
        rd_val[C_UF_BIT]   = uf_ff;
      end
      ADDR_PWR_VALID: begin // [RL19]
        rd_val[D_VRT_BIT] = vrt_ff;
      end
      default: rd_val = REG_ZERO;
    endcase
    nxt_rdata = rd_hit ? rd_val : rdata_ff;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pf_ff     <= 1'b0;
      af_ff     <= 1'b0;
      uf_ff     <= 1'b0;
      vrt_ff    <= 1'b0;
      irq_oe_ff <= 1'b0;
      wave_ff   <= 1'b0;
      rdata_ff  <= REG_ZERO;
    end else begin
      pf_ff     <= nxt_pf;
      af_ff     <= nxt_af;
      uf_ff     <= nxt_uf;
      vrt_ff    <= nxt_vrt;
      irq_oe_ff <= nxt_irq_oe;
      wave_ff   <= nxt_wave;
      rdata_ff  <= nxt_rdata;
    end
  end

  // the request pin only ever pulls low; the value flop is a constant zero
  logic irq_n_ff;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_n_ff <= 1'b0;
    end else begin
      irq_n_ff <= 1'b0;
    end
  end

  assign bus_rdata_out          = rdata_ff;
  assign irq_n_out              = irq_n_ff;
  assign irq_oe_out             = irq_oe_ff; // [RL11]
  assign wave_out_pin_out       = wave_ff;
  assign advance_time_out       = adv_ff;
  assign data_format_select_out = dm_ff; // [RL8]
  assign hour_format_24_out     = h24_ff; // [RL9]
  assign summer_time_enable_out = dse_ff; // [RL10]

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  upd_run_busy_a: assert property (state_ff == UPD_RUN |-> uip_ff) // [RL1]
    else $error("update running without busy flag");
  upd_lead_a: assert property ($rose(state_ff == UPD_RUN) |-> $past(state_ff == UPD_PRE) && $past(cnt_ff) == '0) // [RL2]
    else $error("update began without full lead time");
  hold_stop_a: assert property (set_ff |=> state_ff == UPD_IDLE && !uip_ff && !advance_time_out) // [RL3]
    else $error("update ran while hold bit set");
  clear_en_a: assert property (!chip_clear_n_in |=> !pie_ff && !uie_ff && !square_wave_enable_ff && !aie_ff) // [RL4]
    else $error("chip clear left an enable set");
  pf_masked_a: assert property (pf_ff && !pie_ff && !(af_ff && aie_ff) && !(uf_ff && uie_ff) |=> !irq_oe_out) // [RL5]
    else $error("masked periodic flag drove request");
  uf_req_a: assert property (uf_ff && uie_ff && chip_clear_n_in |=> irq_oe_out) // [RL6]
    else $error("enabled update flag gave no request");
  wave_low_a: assert property (!square_wave_enable_ff |=> !wave_out_pin_out) // [RL7]
    else $error("wave pin active while disabled");
  flag_clr_a: assert property (rd_c && !per_tick && !alarm_match_in && !adv_ff |=> !pf_ff && !af_ff && !uf_ff) // [RL12]
    else $error("flag read did not clear flags");
  flag_wr_a: assert property (bus_sel_in && bus_wr_in && bus_addr_in == ADDR_IRQ_FLAGS && !rd_c && chip_clear_n_in
                              |=> pf_ff == $past(pf_ff | per_tick)) // [RL12]
    else $error("flag write altered periodic flag");
  pf_set_a: assert property (per_tick && chip_clear_n_in |=> pf_ff) // [RL13]
    else $error("periodic event lost");
  alarm_req_a: assert property (alarm_match_in && aie_ff && chip_clear_n_in ##1 aie_ff && chip_clear_n_in |=> irq_oe_out) // [RL14]
    else $error("alarm did not raise request");
  uf_set_a: assert property (adv_ff && chip_clear_n_in |=> uf_ff) // [RL15]
    else $error("update end did not set flag");
  vrt_low_a: assert property (!power_sense_input_in |=> !vrt_ff) // [RL17]
    else $error("valid bit high without power sense");
  vrt_set_a: assert property (rd_d && power_sense_input_in |=> vrt_ff) // [RL18]
    else $error("validity read did not set valid bit");
  low_bits_a: assert property (rd_c |=> bus_rdata_out[C_UF_BIT-1:0] == '0) // [RL16]
    else $error("unused flag bits not zero");
  vrt_bits_a: assert property (rd_d |=> bus_rdata_out[D_VRT_BIT-1:0] == '0) // [RL19]
    else $error("unused validity bits not zero");

  upd_done_c: cover property (state_ff == UPD_RUN ##1 advance_time_out);
  irq_pf_c:   cover property (pf_ff && pie_ff ##1 irq_oe_out);
  hold_c:     cover property (state_ff == UPD_PRE ##1 set_ff);
  vrt_c:      cover property (rd_d && power_sense_input_in ##1 vrt_ff);

endmodule

// *** verif/rtcc_host.sv ***
// Purpose: host processor model on the register port of the clock block
// Assumes: one access per call; strobes last exactly one clock
// Notes:   idle address and data lines carry inverted junk, never the last value
`timescale 1ns/1ns
module rtcc_host (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] bus_rdata_in,
  input  wire logic       irq_n_in,
  input  wire logic       irq_oe_in,
  output logic            bus_sel_out,
  output logic            bus_rd_out,
  output logic            bus_wr_out,
  output logic      [5:0] bus_addr_out,
  output logic      [7:0] bus_wdata_out,
  output logic            irq_line_out
);
  // shared request line has a pull-up at the host side
  assign irq_line_out = irq_oe_in ? irq_n_in : 1'b1;

  initial begin
    bus_sel_out   = 1'b0;
    bus_rd_out    = 1'b0;
    bus_wr_out    = 1'b0;
    bus_addr_out  = 6'h00;
    bus_wdata_out = 8'h00;
  end

  // read data is sampled one full cycle after the taking edge; it holds until the next read
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata);
    @(negedge ref_clk_in);
    bus_sel_out   = 1'b1;
    bus_rd_out    = ~wr;
    bus_wr_out    = wr;
    bus_addr_out  = addr;
    bus_wdata_out = data;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    bus_sel_out   = 1'b0;
    bus_rd_out    = 1'b0;
    bus_wr_out    = 1'b0;
    bus_addr_out  = ~addr;
    bus_wdata_out = ~data;
    @(posedge ref_clk_in);
    #1 rdata = bus_rdata_in;
  endtask
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the clock control, status and interrupt block
// Assumes: short update timing parameters; time base ticks every core cycle
// Notes:   random control values come from a fixed seed
`timescale 1ns/1ns
module testbench;
  import rtcc_pkg::*;

  localparam int unsigned BUC_T = 20;
  localparam int unsigned UCF_T = 30;
  localparam int unsigned UCS_T = 60;
  localparam int unsigned UPD_T = BUC_T + UCS_T;
  localparam logic [7:0]  HOLD  = 8'h80;

  logic       ref_clk_in;
  logic       nrst_in;
  logic       chip_clear_n_in;
  logic       osc_tick_in;
  logic       power_sense_input_in;
  logic       alarm_match_in;
  logic       bus_sel;
  logic       bus_rd;
  logic       bus_wr;
  logic [5:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic       irq_n;
  logic       irq_oe;
  logic       irq_line;
  logic       wave;
  logic       advance;
  logic       fmt;
  logic       h24;
  logic       summer;
  logic [7:0] v;
  logic       seen;
  int         n;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  rtcc_top #(.DIV_W(22), .BUC_CYCLES(BUC_T), .UC_FAST_CYCLES(UCF_T), .UC_SLOW_CYCLES(UCS_T)) i_rtcc_top (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .chip_clear_n_in(chip_clear_n_in),
    .osc_tick_in(osc_tick_in), .power_sense_input_in(power_sense_input_in),
    .alarm_match_in(alarm_match_in), .bus_sel_in(bus_sel), .bus_rd_in(bus_rd), .bus_wr_in(bus_wr),
    .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_rdata_out(bus_rdata), .irq_n_out(irq_n),
    .irq_oe_out(irq_oe), .wave_out_pin_out(wave), .advance_time_out(advance),
    .data_format_select_out(fmt), .hour_format_24_out(h24), .summer_time_enable_out(summer));

  rtcc_host i_rtcc_host (
    .ref_clk_in(ref_clk_in), .bus_rdata_in(bus_rdata), .irq_n_in(irq_n), .irq_oe_in(irq_oe),
    .bus_sel_out(bus_sel), .bus_rd_out(bus_rd), .bus_wr_out(bus_wr), .bus_addr_out(bus_addr),
    .bus_wdata_out(bus_wdata), .irq_line_out(irq_line));

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] unused;
    i_rtcc_host.access(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    i_rtcc_host.access(1'b0, a, 8'h00, d);
  endtask

  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask

  task automatic alarm_pulse();
    @(negedge ref_clk_in);
    alarm_match_in = 1'b1;
    @(negedge ref_clk_in);
    alarm_match_in = 1'b0;
  endtask

  // samples the wave pin 1 ns after each of 32 rising edges and counts the ones
  task automatic wave_ones(output int ones);
    ones = 0;
    repeat (32) begin
      @(posedge ref_clk_in);
      #1 ones += wave;
    end
  endtask

  // polling by reads keeps the bus busy; detection lags the flag by up to three cycles
  task automatic wait_busy();
    logic [7:0] d;
    int         k;
    d = 8'h00;
    k = 0;
    while (d[A_UIP_BIT] !== 1'b1 && k < 40000) begin
      rd(ADDR_RATE_CTRL, d);
      k++;
    end
  endtask

  function automatic logic [7:0] flags_exp(input logic pf, input logic af, input logic uf,
                                           input logic [7:0] ctrl);
    logic sum;
    sum = (pf & ctrl[B_PIE_BIT]) | (af & ctrl[B_AIE_BIT]) | (uf & ctrl[B_UIE_BIT]);
    return {sum, pf, af, uf, 4'h0};
  endfunction

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ceiling covers two slow seconds of polling plus margin, and keeps the run short
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst_in              = 1'b0;
    chip_clear_n_in      = 1'b1;
    osc_tick_in          = 1'b1;
    power_sense_input_in = 1'b0;
    alarm_match_in       = 1'b0;
    void'($urandom(32'h23ae));
    repeat (4) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    rd_check(ADDR_UPD_CTRL, 8'h00);
    rd_check(ADDR_IRQ_FLAGS, 8'h00);
    rd_check(6'h3F, 8'h00);
    check({7'h00, irq_line}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(ADDR_UPD_CTRL, v);
      wr(6'h3F, ~v);
      rd_check(ADDR_UPD_CTRL, v);
      check({5'h00, fmt, h24, summer}, {5'h00, v[2:0]});
    end
    // periodic flag, masked and unmasked, then the wave pin
    wr(ADDR_RATE_CTRL, {1'b0, BASE_SLOW, 4'h3});
    wr(ADDR_UPD_CTRL, HOLD);
    rd(ADDR_IRQ_FLAGS, v);
    cyc(20);
    check({7'h00, irq_line}, 8'h01);
    rd_check(ADDR_IRQ_FLAGS, flags_exp(1'b1, 1'b0, 1'b0, HOLD));
    wr(ADDR_UPD_CTRL, HOLD | 8'h40);
    cyc(20);
    check({7'h00, irq_line}, 8'h00);
    rd_check(ADDR_IRQ_FLAGS, flags_exp(1'b1, 1'b0, 1'b0, HOLD | 8'h40));
    wr(ADDR_UPD_CTRL, HOLD | 8'h08);
    wave_ones(n);
    check(8'(n), 8'h10);
    wr(ADDR_UPD_CTRL, HOLD);
    wave_ones(n);
    check(8'(n), 8'h00);
    wr(ADDR_RATE_CTRL, {1'b0, BASE_SLOW, RATE_OFF});
    rd(ADDR_IRQ_FLAGS, v);
    wr(ADDR_IRQ_FLAGS, 8'hFF);
    rd_check(ADDR_IRQ_FLAGS, 8'h00);
    // alarm flag with and without its enable
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? (HOLD | 8'h20) : HOLD;
      wr(ADDR_UPD_CTRL, v);
      alarm_pulse();
      cyc(3);
      check({7'h00, irq_line}, {7'h00, ~v[B_AIE_BIT]});
      rd_check(ADDR_IRQ_FLAGS, flags_exp(1'b0, 1'b1, 1'b0, v));
      rd_check(ADDR_IRQ_FLAGS, 8'h00);
    end
    // chip clear drops the three enables, wave enable and the three flags only
    wr(ADDR_UPD_CTRL, 8'hFF);
    alarm_pulse();
    cyc(3);
    check({7'h00, irq_line}, 8'h00);
    chip_clear_n_in = 1'b0;
    cyc(1);
    chip_clear_n_in = 1'b1;
    cyc(2);
    check({7'h00, irq_line}, 8'h01);
    check({7'h00, wave}, 8'h00);
    rd_check(ADDR_UPD_CTRL, 8'h87);
    rd_check(ADDR_IRQ_FLAGS, 8'h00);
    // validity bit follows power sense and reads
    rd_check(ADDR_PWR_VALID, 8'h00);
    cyc(1);
    power_sense_input_in = 1'b1;
    rd_check(ADDR_PWR_VALID, 8'h00);
    rd_check(ADDR_PWR_VALID, 8'h80);
    wr(ADDR_PWR_VALID, 8'h7F);
    rd_check(ADDR_PWR_VALID, 8'h80);
    cyc(1);
    power_sense_input_in = 1'b0;
    cyc(1);
    rd_check(ADDR_PWR_VALID, 8'h00);
    // one full update cycle, then one aborted by the hold bit
    wr(ADDR_RATE_CTRL, {1'b0, BASE_SLOW, RATE_OFF});
    wr(ADDR_UPD_CTRL, 8'h10);
    rd(ADDR_IRQ_FLAGS, v);
    wait_busy();
    check({7'h00, irq_line}, 8'h01);
    n = 0;
    while (advance !== 1'b1 && n < 4000) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    check(8'(n >= UPD_T - 4 && n <= UPD_T + 4), 8'h01);
    rd(ADDR_RATE_CTRL, v);
    check(v & 8'h80, 8'h00);
    cyc(2);
    check({7'h00, irq_line}, 8'h00);
    rd_check(ADDR_IRQ_FLAGS, flags_exp(1'b0, 1'b0, 1'b1, 8'h10));
    wait_busy();
    wr(ADDR_UPD_CTRL, HOLD | 8'h10);
    rd(ADDR_RATE_CTRL, v);
    check(v & 8'h80, 8'h00);
    seen = 1'b0;
    repeat (UPD_T + 10) begin
      @(posedge ref_clk_in);
      #1 seen |= advance;
    end
    check({7'h00, seen}, 8'h00);
    rd_check(ADDR_IRQ_FLAGS, 8'h00);
    report_and_stop();
  end
endmodule
